/* lcfg_top.sv */
// Fault latching, acknowledge-by-read and laser channel gating.
// Assumes a register port from the serial front end with one-cycle strobes
// and condition levels already synchronous to clk.
`timescale 1ns/1ps
module lcfg_top
  import lcfg_pkg::*;
#(
  parameter int TIMEOUT_CYC = REG_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire lcfg_chan_t chan1,
  input wire lcfg_chan_t chan2,
  input wire lcfg_glob_t glob,
  output logic laserOn1,
  output logic laserOn2,
  output logic regulate1,
  output logic regulate2,
  output logic parallelCh2,
  output logic pulsedOut1,
  output logic pulsedOut2,
  output logic faultPinOut,
  output logic faultPinOe
);

  // ==========================================================
  // Configuration registers
  logic [7:0] comp1_ff;
  logic [7:0] comp2_ff;
  logic [7:0] limit1_ff;
  logic [7:0] limit2_ff;
  logic [7:0] combine_ff;
  logic [7:0] mask_ff;
  logic [7:0] chanCtrl_ff;
  logic [7:0] modeCtrl_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic standby_ff;
  logic [7:0] fstatPrev_ff;
  logic [7:0] cstatPrev_ff;
  logic faultPend_ff;
  logic nxt_faultPend;
  logic [1:0] laserOn_ff;
  logic [1:0] nxt_laserOn;
  logic [1:0] regulate_ff;
  logic [1:0] nxt_regulate;
  logic parallel_ff;
  logic [TMO_W-1:0] offCnt_ff [2];

  // Address decode used by both read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  wire wrComp1 = regWr && hit(regAddr, ADDR_COMP1);
  wire wrComp2 = regWr && hit(regAddr, ADDR_COMP2);
  wire wrLim1 = regWr && hit(regAddr, ADDR_LIMIT1);
  wire wrLim2 = regWr && hit(regAddr, ADDR_LIMIT2);
  wire wrComb = regWr && hit(regAddr, ADDR_COMBINE);
  wire wrMask = regWr && hit(regAddr, ADDR_MASK);
  wire wrChan = regWr && hit(regAddr, ADDR_CHAN_CTRL);
  wire wrMode = regWr && hit(regAddr, ADDR_MODE_CTRL);
  wire rdFault = regRd && hit(regAddr, ADDR_FAULT_STATUS);
  wire rdChan = regRd && hit(regAddr, ADDR_CHANNEL_STATUS);

  // ==========================================================
  // Per-channel mode view
  wire [1:0] pulsed = {comp2_ff[BIT_PULSED], comp1_ff[BIT_PULSED]};
  wire [1:0] curFb = {modeCtrl_ff[BIT_CURFB2], modeCtrl_ff[BIT_CURFB1]};
  wire [1:0] linRef = {modeCtrl_ff[BIT_LINREF2], modeCtrl_ff[BIT_LINREF1]};
  wire [1:0] limZero = {limit2_ff == LIMIT_OFF, limit1_ff == LIMIT_OFF};
  wire [1:0] chDisable = {chanCtrl_ff[BIT_DISABLE2], chanCtrl_ff[BIT_DISABLE1]};
  wire [1:0] enPin = {chan2.enablePin, chan1.enablePin};
  wire combine = combine_ff[BIT_COMBINE];

  // Overcurrent qualification; the linear reference always blocks it
  wire [1:0] ovcBlock = linRef | (pulsed & (curFb | limZero));
  wire [1:0] ovcHit = {chan2.overcurrent, chan1.overcurrent} & ~ovcBlock;

  // ==========================================================
  // Standby exit detection: falling edge of the standby level
  wire standbyExit = standby_ff && !glob.standby;

  // Fault status set and hold vectors
  logic [7:0] fSet;
  logic [7:0] fHold;
  assign fSet[BIT_RAM_INIT] = 1'b0;
  assign fSet[BIT_SUPPLY_DOWN] = glob.supplyDown || standbyExit;
  assign fSet[BIT_MEM_ERR] = glob.memError;
  assign fSet[BIT_OVER_TEMP] = glob.overTemp;
  assign fSet[BIT_OVERCURRENT_CH2] = ovcHit[1];
  assign fSet[BIT_OVERCURRENT_CH1] = ovcHit[0];
  assign fSet[BIT_OSC_ERR] = glob.oscError;
  assign fSet[BIT_CFG_TIMEOUT] = glob.cfgTimeout;
  // Standby exit is a one-cycle cause, so only the supply level holds bit 1
  assign fHold = {fSet[7:2], glob.supplyDown, 1'b0};

  logic [7:0] fStat;
  lcfg_evt_latch #(
    .W(8),
    .RST_VAL(RST_FAULT_STATUS)
  ) u_fault (
    .clk(clk),
    .rst_n(rst_n),
    .setVec(fSet),
    .holdVec(fHold),
    .clrRead(rdFault),
    .stat(fStat)
  );

  // ==========================================================
  // Channel status: mode state is live, the rest are latches
  logic [7:0] cSet;
  logic [7:0] cLive;
  logic [7:0] cStat;
  logic [7:0] cView;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      lcfg_chan_t cv;
      assign cv = (ch == 0) ? chan1 : chan2;
      assign cSet[ch*CH_STRIDE + BIT_MODE_STATE] = 1'b0;
      assign cSet[ch*CH_STRIDE + BIT_MON_SEEN] = cv.monitorOn;
      assign cSet[ch*CH_STRIDE + BIT_SATURATION] = cv.saturation;
      assign cSet[ch*CH_STRIDE + BIT_LSUPPLY_DOWN] = cv.supplyDown;
      // Mode state reads 1 in power feedback, 0 in current feedback
      assign cLive[ch*CH_STRIDE + BIT_MODE_STATE] = !curFb[ch];
      assign cLive[ch*CH_STRIDE + BIT_MON_SEEN] = 1'b0;
      assign cLive[ch*CH_STRIDE + BIT_SATURATION] = 1'b0;
      assign cLive[ch*CH_STRIDE + BIT_LSUPPLY_DOWN] = 1'b0;
    end
  endgenerate

  lcfg_evt_latch #(
    .W(8),
    .RST_VAL(RST_CHANNEL_STATUS)
  ) u_chan (
    .clk(clk),
    .rst_n(rst_n),
    .setVec(cSet),
    .holdVec(cSet),
    .clrRead(rdChan),
    .stat(cStat)
  );
  assign cView = cStat | cLive;

  // ==========================================================
  // Laser gating: any latched disabling error keeps both channels off
  wire errPending = |(fStat & FAULT_GATE_MASK) || |(cStat & CHAN_GATE_MASK);
  // In combine mode channel 2 needs both channel 1's gate and its own
  wire [1:0] gateBase = enPin & ~chDisable;
  assign nxt_laserOn[0] = gateBase[0] && !errPending;
  assign nxt_laserOn[1] = (combine ? (gateBase[0] && gateBase[1]) : gateBase[1]) && !errPending;

  // ==========================================================
  // Regulation timeout: counts laser-off time in pulsed power feedback only.
  // Current feedback or continuous mode clears the counter, so no timeout.
  generate
    for (ch = 0; ch < 2; ch++) begin : g_tmo
      wire armed = pulsed[ch] && !curFb[ch] && !enPin[ch];
      wire expired = (offCnt_ff[ch] >= TMO_W'(TIMEOUT_CYC));
      assign nxt_regulate[ch] = !(armed && expired);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          offCnt_ff[ch] <= '0;
        end else if (!armed) begin
          offCnt_ff[ch] <= '0;
        end else if (!expired) begin
          offCnt_ff[ch] <= offCnt_ff[ch] + TMO_W'(1);
        end
      end
    end
  endgenerate

  // ==========================================================
  // Fault pin: unmasked status changes raise it until a status read
  wire [7:0] fMaskVec = {1'b0, mask_ff[BIT_MASK_OSC], 6'h00};
  wire [7:0] cMaskVec = {1'b0, mask_ff[BIT_MASK_SAT2], 3'h0, mask_ff[BIT_MASK_SAT1], 2'h0};
  wire fChange = |((fStat ^ fstatPrev_ff) & ~fMaskVec);
  wire cChange = |((cView ^ cstatPrev_ff) & ~cMaskVec);
  // A change in the read cycle still wins, so no event is lost
  assign nxt_faultPend = fChange || cChange || (faultPend_ff && !(rdFault || rdChan));

  // ==========================================================
  // Read mux; unmapped offsets read zero
  assign nxt_rdata = !regRd ? rdata_ff :
    hit(regAddr, ADDR_FAULT_STATUS) ? fStat :
    hit(regAddr, ADDR_CHANNEL_STATUS) ? cView :
    hit(regAddr, ADDR_LIMIT1) ? limit1_ff :
    hit(regAddr, ADDR_COMP1) ? comp1_ff :
    hit(regAddr, ADDR_LIMIT2) ? limit2_ff :
    hit(regAddr, ADDR_COMP2) ? comp2_ff :
    hit(regAddr, ADDR_COMBINE) ? combine_ff :
    hit(regAddr, ADDR_MASK) ? mask_ff :
    hit(regAddr, ADDR_CHAN_CTRL) ? chanCtrl_ff :
    hit(regAddr, ADDR_MODE_CTRL) ? modeCtrl_ff : 8'h00;

  // Writable configuration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comp1_ff <= RST_COMP;
      comp2_ff <= RST_COMP;
      limit1_ff <= RST_LIMIT;
      limit2_ff <= RST_LIMIT;
      combine_ff <= RST_COMBINE;
      mask_ff <= RST_MASK;
      chanCtrl_ff <= RST_CHAN_CTRL;
      modeCtrl_ff <= RST_MODE_CTRL;
    end else begin
      if (wrComp1) comp1_ff <= regWdata;
      if (wrComp2) comp2_ff <= regWdata;
      if (wrLim1) limit1_ff <= regWdata;
      if (wrLim2) limit2_ff <= regWdata;
      if (wrComb) combine_ff <= regWdata;
      if (wrMask) mask_ff <= regWdata;
      if (wrChan) chanCtrl_ff <= regWdata;
      if (wrMode) modeCtrl_ff <= regWdata;
    end
  end

  // Edge trackers and registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_ff <= 1'b0;
      fstatPrev_ff <= RST_FAULT_STATUS;
      cstatPrev_ff <= RST_CHANNEL_STATUS;
      faultPend_ff <= 1'b1; // Power-on bits count as a change
      rdata_ff <= 8'h00;
      laserOn_ff <= 2'b00;
      regulate_ff <= 2'b11;
      parallel_ff <= 1'b0;
    end else begin
      standby_ff <= glob.standby;
      fstatPrev_ff <= fStat;
      cstatPrev_ff <= cView;
      faultPend_ff <= nxt_faultPend;
      rdata_ff <= nxt_rdata;
      laserOn_ff <= nxt_laserOn;
      regulate_ff <= nxt_regulate;
      parallel_ff <= combine;
    end
  end

  assign regRdata = rdata_ff;
  assign laserOn1 = laserOn_ff[0];
  assign laserOn2 = laserOn_ff[1];
  assign regulate1 = regulate_ff[0];
  assign regulate2 = regulate_ff[1];
  assign parallelCh2 = parallel_ff;
  assign pulsedOut1 = comp1_ff[BIT_PULSED];
  assign pulsedOut2 = comp2_ff[BIT_PULSED];
  // Open drain: only ever pulls low
  assign faultPinOut = 1'b0;
  assign faultPinOe = faultPend_ff;

endmodule // lcfg_top

/* lcfg_pkg.sv */
// Constants, register map and carrier types for the laser channel fault gate.
// Assumes a single 10 MHz clock and a register port driven by a serial front end.
// Functional notes
// - Fault status bits 0..7: ram init, supply down, mem error, overtemp, overcurrent_ch2, overcurrent_ch1, osc, cfg timeout.
// - Channel status: per channel mode state, monitor seen, saturation, laser supply down.
// - Monitor seen bit latches on first monitor enable and holds until read.
// - Channels stay off while errors unacknowledged; reading status acknowledges them.
// - Power-on sets supply down, both laser supply down and ram initialized bits.
// - Leaving standby keeps configuration but sets supply down, disabling channels.
// - Overcurrent on either channel or overtemperature disables the laser outputs.
// - Memory validation error or configuration timeout also forces outputs off.
// - Pulsed operation enabled by bit 7 of 0x13 and 0x18, reset value zero.
// - In pulsed operation the enable pin switches current; regulator holds its point.
// - Power feedback pulsed: regulation disconnects after laser off at least 300 us.
// - Current feedback mode has no regulation timeout.
// - Pulsed: overcurrent off in current feedback, or threshold 0x00 in power feedback.
// - Overcurrent detection off whenever linear reference select is set.
// - Combine bit 1: channel 2 transistor parallels channel 1 regulation; 0 independent.
// - Every unmasked change in either status register is signalled on the fault pin.
// - Channel disable bits reset to 1, keeping channels off until written 0.
// - Laser supply down bits are event latches cleared by reading.
package lcfg_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CHANNEL_STATUS = 8'h01;
  localparam logic [7:0] ADDR_LIMIT1 = 8'h11;
  localparam logic [7:0] ADDR_COMP1 = 8'h13;
  localparam logic [7:0] ADDR_LIMIT2 = 8'h16;
  localparam logic [7:0] ADDR_COMP2 = 8'h18;
  localparam logic [7:0] ADDR_COMBINE = 8'h1b;
  localparam logic [7:0] ADDR_MASK = 8'h1d;
  localparam logic [7:0] ADDR_CHAN_CTRL = 8'h20;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h21;

  // ==========================================================
  // Field positions
  localparam int BIT_RAM_INIT = 0;
  localparam int BIT_SUPPLY_DOWN = 1;
  localparam int BIT_MEM_ERR = 2;
  localparam int BIT_OVER_TEMP = 3;
  localparam int BIT_OVERCURRENT_CH2 = 4;
  localparam int BIT_OVERCURRENT_CH1 = 5;
  localparam int BIT_OSC_ERR = 6;
  localparam int BIT_CFG_TIMEOUT = 7;
  localparam int CH_STRIDE = 4;      // Channel 2 fields sit 4 bits above channel 1
  localparam int BIT_MODE_STATE = 0;
  localparam int BIT_MON_SEEN = 1;
  localparam int BIT_SATURATION = 2;
  localparam int BIT_LSUPPLY_DOWN = 3;
  localparam int BIT_PULSED = 7;
  localparam int BIT_COMBINE = 6;
  localparam int BIT_MASK_OSC = 0;
  localparam int BIT_MASK_SAT1 = 2;
  localparam int BIT_MASK_SAT2 = 3;
  localparam int BIT_DISABLE1 = 0;
  localparam int BIT_DISABLE2 = 1;
  localparam int BIT_CURFB1 = 0;
  localparam int BIT_CURFB2 = 1;
  localparam int BIT_LINREF1 = 2;
  localparam int BIT_LINREF2 = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_FAULT_STATUS = 8'h03;   // ram init + supply down
  localparam logic [7:0] RST_CHANNEL_STATUS = 8'h88; // both laser supply down
  localparam logic [7:0] RST_COMP = 8'h30;
  localparam logic [7:0] RST_LIMIT = 8'hff;
  localparam logic [7:0] RST_COMBINE = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h0c;
  localparam logic [7:0] RST_CHAN_CTRL = 8'h03;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] LIMIT_OFF = 8'h00;
  // Fault bits that keep lasers off; oscillator error only adds an offset
  localparam logic [7:0] FAULT_GATE_MASK = 8'hbf;
  localparam logic [7:0] CHAN_GATE_MASK = 8'h88;

  // ==========================================================
  // Timing
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int REG_TIMEOUT_US = 300;
  localparam int REG_TIMEOUT_CYC = (REG_TIMEOUT_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int TMO_W = 12;

  // ==========================================================
  // Carrier of per-channel analog condition levels
  typedef struct packed {
    logic overcurrent;
    logic monitorOn;
    logic saturation;
    logic supplyDown;
    logic enablePin;
  } lcfg_chan_t;

  // Carrier of device-wide condition levels
  typedef struct packed {
    logic memError;
    logic overTemp;
    logic oscError;
    logic cfgTimeout;
    logic supplyDown;
    logic standby;
  } lcfg_glob_t;

endpackage

/* lcfg_evt_latch.sv */
// Bank of sticky status bits, cleared by a read unless the cause persists.
// Assumes the read strobe is a one-cycle pulse in the same clock domain.
`timescale 1ns/1ps
module lcfg_evt_latch #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] setVec,
  input wire logic [W-1:0] holdVec,
  input wire logic clrRead,
  output logic [W-1:0] stat
);
  logic [W-1:0] stat_ff;
  logic [W-1:0] nxt_stat;
  logic [W-1:0] clrVec;

  // ==========================================================
  // Clear only bits whose cause has gone; a new set beats the clear
  assign clrVec = clrRead ? ~holdVec : '0;
  assign nxt_stat = (stat_ff & ~clrVec) | setVec;
  assign stat = stat_ff;

  // Latch register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= RST_VAL;
    end else begin
      stat_ff <= nxt_stat;
    end
  end
endmodule // lcfg_evt_latch

/* lcfg_top_monitor.sv */
// Port-level checker for the laser channel fault gate, bound to lcfg_top.
// Assumes one clock domain and the active-low asynchronous reset of the top.
`timescale 1ns/1ps
module lcfg_top_monitor
  import lcfg_pkg::*;
#(
  parameter int TIMEOUT_CYC = REG_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire lcfg_chan_t chan1,
  input wire lcfg_chan_t chan2,
  input wire lcfg_glob_t glob,
  input wire logic laserOn1,
  input wire logic laserOn2,
  input wire logic regulate1,
  input wire logic parallelCh2,
  input wire logic pulsedOut1,
  input wire logic faultPinOut,
  input wire logic faultPinOe
);
  // ==========================================================
  // Helper: cycles the channel 1 pin has stayed low, saturating
  logic [15:0] lowCnt_ff;
  logic [15:0] nxt_lowCnt;
  assign nxt_lowCnt = chan1.enablePin ? 16'h0000 : lowCnt_ff + {15'h0000, lowCnt_ff != 16'hffff};

  // Counter register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lowCnt_ff <= 16'h0000;
    else lowCnt_ff <= nxt_lowCnt;
  end

  // ==========================================================
  // Assertions, all on the single clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_pin_gates_one: assert property (laserOn1 |-> $past(chan1.enablePin))
    else $error("laser 1 on without its enable pin");
  chk_pin_gates_two: assert property (laserOn2 |-> $past(chan2.enablePin))
    else $error("laser 2 on without its enable pin");
  chk_heat_kills_lasers: assert property (glob.overTemp |-> ##3 (!laserOn1 && !laserOn2))
    else $error("lasers still on after overtemperature");
  chk_timeout_not_early: assert property ($fell(regulate1) |-> lowCnt_ff >= TIMEOUT_CYC)
    else $error("regulation dropped before the timeout");
  chk_regulate_restore: assert property (chan1.enablePin [*3] |-> regulate1)
    else $error("regulation not restored with pin high");
  chk_rdata_holds: assert property (!regRd |=> $stable(regRdata))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (regRd && regAddr == 8'h05 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_pulsed_bit: assert property (regWr && regAddr == ADDR_COMP1 ##1 !(regWr && regAddr == ADDR_COMP1)
    |=> pulsedOut1 == $past(regWdata[7], 2))
    else $error("pulsed enable does not follow its bit");
  chk_fault_pin_ack: assert property ($fell(faultPinOe) |-> $past(regRd) && $past(regAddr) <= 8'h01)
    else $error("fault pin released without a status read");
  chk_drain_low: assert property (faultPinOut == 1'b0)
    else $error("fault pin output not low");

  // Main scenarios reached
  cover property (laserOn1 && laserOn2);
  cover property ($fell(regulate1));
  cover property (parallelCh2 && laserOn2);
endmodule // lcfg_top_monitor

bind lcfg_top lcfg_top_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_mon (.clk(clk), .rst_n(rst_n), .regWr(regWr),
  .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .chan1(chan1), .chan2(chan2),
  .glob(glob), .laserOn1(laserOn1), .laserOn2(laserOn2), .regulate1(regulate1), .parallelCh2(parallelCh2),
  .pulsedOut1(pulsedOut1), .faultPinOut(faultPinOut), .faultPinOe(faultPinOe));

/* lcfg_mcu_model.sv */
// Behavioural controller on the register port of the fault gate.
// Assumes strobes are taken on the rising edge; it drives on the falling edge.
`timescale 1ns/1ps
module lcfg_mcu_model
  import lcfg_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  // ==========================================================
  // Extra idle cycles before each access, to act slowly when asked
  int idle = 0;

  // Idle bus at time zero
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // One-cycle write strobe; a gap always follows, so strobes never merge
  task automatic put(input logic [7:0] a, input logic [7:0] dat);
    repeat (idle) @(negedge clk);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = dat;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~dat;
  endtask

  // One-cycle read strobe; a status read is also the acknowledge
  task automatic get(input logic [7:0] a, output logic [7:0] dat);
    repeat (idle) @(negedge clk);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    dat = rdata;
  endtask
endmodule // lcfg_mcu_model

/* test_laser_channel_fault_gate.sv */
// Self-checking bench for the laser channel fault gate.
// Assumes lcfg_top, the controller model and the bound monitor are compiled first.
`timescale 1ns/1ps
module test_laser_channel_fault_gate;
  import lcfg_pkg::*;
  // ==========================================================
  // Signals and tables
  localparam int TCYC = 20;
  logic clk = 1'b0;
  logic rst_n;
  logic regWr, regRd, laserOn1, laserOn2, regulate1, regulate2, parallelCh2, pulsedOut1, pulsedOut2, faultPinOut, faultPinOe;
  logic [7:0] regAddr, regWdata, regRdata, d;
  lcfg_chan_t c1, c2;
  lcfg_glob_t g;
  int errors = 0;
  int checks = 0;
  logic [31:0] seed = 32'h861a4688;
  logic [7:0] expv [9] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h80, 8'h40, 8'h91, 8'h13, 8'h15};
  logic [7:0] modev [4] = '{8'h01, 8'h00, 8'h00, 8'h04};
  logic [7:0] limv [4] = '{8'hff, 8'h00, 8'h01, 8'hff};
  logic [7:0] ovcv [4] = '{8'h00, 8'h00, 8'h20, 8'h00};

  // 10 MHz clock
  always #50 clk = ~clk;

  // Device and controller model
  lcfg_top #(.TIMEOUT_CYC(TCYC)) i_dut (.clk(clk), .rst_n(rst_n), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .chan1(c1), .chan2(c2), .glob(g),
    .laserOn1(laserOn1), .laserOn2(laserOn2), .regulate1(regulate1), .regulate2(regulate2), .parallelCh2(parallelCh2),
    .pulsedOut1(pulsedOut1), .pulsedOut2(pulsedOut2), .faultPinOut(faultPinOut), .faultPinOe(faultPinOe));
  lcfg_mcu_model i_mcu (.clk(clk), .rdata(regRdata), .wr(regWr), .rd(regRd), .addr(regAddr), .wdata(regWdata));

  // ==========================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chb(input string nm, input logic seen, input logic exp);
    chk(nm, {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Stimulus helpers and expectation functions
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] gate(input logic e1, input logic e2, input logic [1:0] ds, input logic cb);
    logic a1;
    logic a2;
    a1 = e1 & ~ds[0];
    a2 = e2 & ~ds[1];
    return {cb ? (a1 & a2) : a2, a1};
  endfunction
  task automatic cause(input int i, input logic v);
    case (i)
      0: c1.overcurrent = v;
      1: c2.overcurrent = v;
      2: g.overTemp = v;
      3: g.memError = v;
      4: g.cfgTimeout = v;
      5: g.oscError = v;
      6: c2.supplyDown = v;
      7: c1.monitorOn = v;
      default: c1.saturation = v;
    endcase
  endtask

  // Hang guard: a run this long counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    c1 = '0;
    c2 = '0;
    g = '0;
    wt(5);
    rst_n = 1'b1;
    i_mcu.get(ADDR_FAULT_STATUS, d);
    chk("fault status at power-on", d, RST_FAULT_STATUS);
    i_mcu.get(ADDR_CHANNEL_STATUS, d);
    chk("channel status at power-on", d, 8'h99);
    i_mcu.get(ADDR_FAULT_STATUS, d);
    chk("fault status acknowledged", d, 8'h00);
    i_mcu.get(ADDR_CHANNEL_STATUS, d);
    chk("channel status acknowledged", d, 8'h11);
    chb("fault pin after reads", faultPinOe, 1'b0);
    i_mcu.get(ADDR_CHAN_CTRL, d);
    chk("channel control reset", d, RST_CHAN_CTRL);
    chb("pulsed 2 at reset", pulsedOut2, 1'b0);
    chb("regulation 2 at reset", regulate2, 1'b1);
    c1.enablePin = 1'b1;
    c2.enablePin = 1'b1;
    wt(3);
    chb("laser 1 while disabled", laserOn1, 1'b0);
    i_mcu.put(ADDR_CHAN_CTRL, 8'h00);
    wt(3);
    chk("both lasers enabled", {6'h00, laserOn2, laserOn1}, 8'h03);
    // Nine status causes, latched and acknowledged; all but masked channel 1 saturation signalled
    for (int i = 0; i < 9; i++) begin
      cause(i, 1'b1);
      wt(1);
      cause(i, 1'b0);
      wt(3);
      chb("laser 1 after cause", laserOn1, i == 5 || i > 6);
      chb("fault pin after cause", faultPinOe, i != 8);
      i_mcu.get({7'h00, i > 5}, d);
      chk("latched status", d, expv[i]);
      // The acknowledge is itself a status change, so a second read drops the pin
      i_mcu.get({7'h00, i > 5}, d);
      chb("fault pin after second read", faultPinOe, 1'b0);
      wt(3);
      chb("laser 1 after acknowledge", laserOn1, 1'b1);
    end
    // A cause still present at the read keeps its bit
    g.overTemp = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (k == 2) g.overTemp = 1'b0;
      i_mcu.get(ADDR_FAULT_STATUS, d);
      chk("held status", d, (k < 3) ? 8'h08 : 8'h00);
    end
    // Standby exit needs one fault status read
    g.standby = 1'b1;
    wt(2);
    g.standby = 1'b0;
    wt(3);
    chb("laser after standby", laserOn1, 1'b0);
    i_mcu.get(ADDR_FAULT_STATUS, d);
    chk("standby status", d, 8'h02);
    wt(3);
    chb("laser re-enabled", laserOn1, 1'b1);
    i_mcu.put(ADDR_FAULT_STATUS, 8'hff);
    i_mcu.get(8'h05, d);
    i_mcu.get(ADDR_FAULT_STATUS, d);
    chk("status write ignored", d, 8'h00);
    // Pulsed operation and overcurrent masking
    i_mcu.put(ADDR_COMP1, 8'hb0); // capacitor assumed fitted
    i_mcu.put(ADDR_COMP2, 8'hb0);
    wt(2);
    chb("pulsed enable", pulsedOut1, 1'b1);
    chb("pulsed enable 2", pulsedOut2, 1'b1);
    for (int k = 0; k < 4; k++) begin
      i_mcu.put(ADDR_MODE_CTRL, modev[k]);
      i_mcu.put(ADDR_LIMIT1, limv[k]);
      cause(0, 1'b1);
      wt(1);
      cause(0, 1'b0);
      wt(3);
      i_mcu.get(ADDR_FAULT_STATUS, d);
      chk("pulsed overcurrent", d, ovcv[k]);
    end
    // Regulation timeout in power feedback, none in current feedback
    i_mcu.put(ADDR_MODE_CTRL, 8'h00);
    c1.enablePin = 1'b0;
    c2.enablePin = 1'b0;
    wt(3);
    chb("pulsed laser off", laserOn1, 1'b0);
    wt(12);
    chb("still regulating", regulate1, 1'b1);
    chb("still regulating 2", regulate2, 1'b1);
    wt(TCYC);
    chb("regulation timed out", regulate1, 1'b0);
    chb("regulation 2 timed out", regulate2, 1'b0);
    c1.enablePin = 1'b1;
    c2.enablePin = 1'b1;
    wt(3);
    chb("regulation restored", regulate1, 1'b1);
    chb("regulation 2 restored", regulate2, 1'b1);
    i_mcu.put(ADDR_MODE_CTRL, 8'h01);
    c1.enablePin = 1'b0;
    wt(TCYC + 10);
    chb("no timeout in current feedback", regulate1, 1'b1);
    // Channel combining
    c1.enablePin = 1'b1;
    i_mcu.put(ADDR_MODE_CTRL, 8'h00);
    i_mcu.put(ADDR_COMBINE, 8'h40);
    wt(2);
    chb("parallel output", parallelCh2, 1'b1);
    c1.enablePin = 1'b0;
    wt(3);
    chb("combined laser 2", laserOn2, 1'b0);
    // Random pins, disables and combine, with a slow controller at times
    for (int k = 0; k < 40; k++) begin
      seed = lfsr(seed);
      i_mcu.idle = int'(seed[6:5]);
      c1.enablePin = seed[3];
      c2.enablePin = seed[4];
      i_mcu.put(ADDR_CHAN_CTRL, {6'h00, seed[1:0]});
      i_mcu.put(ADDR_COMBINE, {1'b0, seed[2], 6'h00});
      wt(17);
      chk("laser pair", {6'h00, laserOn2, laserOn1}, {6'h00, gate(seed[3], seed[4], seed[1:0], seed[2])});
    end
    end_sim();
  end
endmodule // test_laser_channel_fault_gate
